// ===== rtl/xcd_pkg.sv
// Package for the X-capacitor discharge sequencer: states, levels, timing.
// Assumes a 100 MHz ref_clk and a one-millisecond tick derived from it.
package xcd_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ          = 100_000_000;
    localparam int unsigned TICK_MS         = 1;
    localparam int unsigned TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned DETECT_MS       = 84;
    localparam int unsigned STEP_MS         = 12;
    localparam int unsigned LAST_STEP_MS    = 48;
    localparam int unsigned DISCHARGE_MS    = 300;
    localparam int unsigned BLANK_MS        = 700;
    localparam int unsigned MS_W            = 10;
    localparam int unsigned TICK_W          = 17;

    // ------------------------------------------------------------
    // Test current levels
    // ------------------------------------------------------------
    localparam logic [1:0] LEVEL_FIRST      = 2'h0;
    localparam logic [1:0] LEVEL_LAST       = 2'h3;
    localparam logic [1:0] LEVEL_RESET      = 2'h0;

    typedef enum logic [2:0] {
        XCD_POWERUP,
        XCD_SHORT_TEST,
        XCD_DETECT,
        XCD_DISCHARGE,
        XCD_BLANK,
        XCD_DISABLED
    } xcd_state_t;

endpackage

// ===== rtl/xcd_ms_timer.sv
// Millisecond tick generator and restartable millisecond counter.
// Assumes restart is a one-cycle pulse from the same clock domain.
`timescale 1ns/100ps
module xcd_ms_timer
    import xcd_pkg::*;
#(
    // Cycles per tick; a shorter tick lets the long intervals fit in a simulation run
    parameter int unsigned TICK_LEN = TICK_CYCLES
) (
    input  wire logic                  ref_clk,
    input  wire logic                  rst,
    input  wire logic                  restart,
    output logic      [xcd_pkg::MS_W-1:0] ms_count
);
    logic [TICK_W-1:0] tick_q;
    logic              tick;

    // ------------------------------------------------------------
    // Tick prescaler, realigned on restart so intervals are whole ms
    // ------------------------------------------------------------
    assign tick = (tick_q == TICK_W'(TICK_LEN - 1));

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tick_q <= '0;
        end else if (restart || tick) begin
            tick_q <= '0;
        end else begin
            tick_q <= tick_q + TICK_W'(1);
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ms_count <= '0;
        end else if (restart) begin
            ms_count <= '0;
        end else if (tick && ms_count != '1) begin
            ms_count <= ms_count + MS_W'(1);
        end
    end

    chk_tick_period: assert property (@(posedge ref_clk) disable iff (rst)
        tick |=> !tick [*8])
        else $error("ms tick repeats too soon");

endmodule

// ===== rtl/xcd_sequencer.sv
// X-capacitor discharge sequencer: stair-case test current, line-loss
// detection, bounded discharge and blanking wait.
// Assumes analog comparator outputs arrive asynchronously from the pins.
`timescale 1ns/100ps
module xcd_sequencer
    import xcd_pkg::*;
#(
    parameter int unsigned TICK_LEN = TICK_CYCLES
) (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       supply_on,
    input  wire logic       wake_out,
    input  wire logic       line_zero_cross,
    input  wire logic       sense_low,
    output logic            short_test_en,
    output logic            test_current_en,
    output logic      [1:0] test_level,
    output logic            discharge_en,
    output logic            line_loss_latch,
    output logic            function_disabled
);
    logic [2:0]      zc_sync_q;
    logic [1:0]      low_sync_q;
    logic [1:0]      wake_sync_q;
    logic [1:0]      sup_sync_q;
    logic            zc_seen;
    logic            sense_short;
    logic            wake_s;
    logic            supply_s;
    xcd_state_t      state_q;
    xcd_state_t      state_d;
    logic [1:0]      level_q;
    logic            restart;
    logic [MS_W-1:0] ms_count;
    logic            step_done;

    // ------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------
    // Zero-crossing is taken on the rising edge after two stages
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            zc_sync_q   <= '0;
            low_sync_q  <= '0;
            wake_sync_q <= '0;
            sup_sync_q  <= '0;
        end else begin
            zc_sync_q   <= {zc_sync_q[1:0], line_zero_cross};
            low_sync_q  <= {low_sync_q[0], sense_low};
            wake_sync_q <= {wake_sync_q[0], wake_out};
            sup_sync_q  <= {sup_sync_q[0], supply_on};
        end
    end

    assign zc_seen     = zc_sync_q[1] && !zc_sync_q[2];
    assign sense_short = low_sync_q[1];
    assign wake_s      = wake_sync_q[1];
    assign supply_s    = sup_sync_q[1];

    // ------------------------------------------------------------
    // Interval timer
    // ------------------------------------------------------------
    assign restart = (state_d != state_q) || (state_q == XCD_DETECT && step_done);

    xcd_ms_timer #(
        .TICK_LEN (TICK_LEN)
    ) u_timer (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .restart  (restart),
        .ms_count (ms_count)
    );

    // Step length depends on the level; the four steps sum to the window
    always_comb begin
        if (level_q == LEVEL_LAST) begin
            step_done = (ms_count >= MS_W'(LAST_STEP_MS));
        end else begin
            step_done = (ms_count >= MS_W'(STEP_MS));
        end
    end

    // ------------------------------------------------------------
    // State machine
    // ------------------------------------------------------------
    // Supply restart cycles do not reset the sequencer on purpose
    always_comb begin
        state_d = state_q;
        case (state_q)
            XCD_POWERUP: begin
                if (supply_s) begin
                    state_d = XCD_SHORT_TEST;
                end
            end
            XCD_SHORT_TEST: begin
                if (sense_short) begin
                    state_d = XCD_DISABLED;
                end else if (wake_s) begin
                    state_d = XCD_DETECT;
                end
            end
            XCD_DETECT: begin
                if (zc_seen) begin
                    state_d = XCD_BLANK;
                end else if (step_done && level_q == LEVEL_LAST) begin
                    state_d = XCD_DISCHARGE;
                end
            end
            XCD_DISCHARGE: begin
                if (ms_count >= MS_W'(DISCHARGE_MS)) begin
                    state_d = XCD_BLANK;
                end
            end
            XCD_BLANK: begin
                if (ms_count >= MS_W'(BLANK_MS)) begin
                    state_d = XCD_DETECT;
                end
            end
            XCD_DISABLED: begin
                state_d = XCD_DISABLED;
            end
            default: begin
                state_d = XCD_POWERUP;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_q <= XCD_POWERUP;
        end else begin
            state_q <= state_d;
        end
    end

    // Stair-case level, restarted from the lowest on each window entry
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            level_q <= LEVEL_RESET;
        end else if (state_q != XCD_DETECT) begin
            level_q <= LEVEL_FIRST;
        end else if (step_done && !zc_seen && level_q != LEVEL_LAST) begin
            level_q <= level_q + 2'h1;
        end
    end

    // Latch set on confirmed loss, cleared when the blanking wait ends
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            line_loss_latch <= 1'b0;
        end else if (state_d == XCD_DISCHARGE && state_q == XCD_DETECT) begin
            line_loss_latch <= 1'b1;
        end else if (state_q == XCD_BLANK && state_d == XCD_DETECT) begin
            line_loss_latch <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            short_test_en     <= 1'b0;
            test_current_en   <= 1'b0;
            test_level        <= LEVEL_RESET;
            discharge_en      <= 1'b0;
            function_disabled <= 1'b0;
        end else begin
            short_test_en     <= (state_d == XCD_SHORT_TEST);
            test_current_en   <= (state_d == XCD_DETECT);
            test_level        <= (state_d == XCD_DETECT && state_q == XCD_DETECT &&
                                  step_done && level_q != LEVEL_LAST) ? level_q + 2'h1 :
                                 (state_d == XCD_DETECT && state_q == XCD_DETECT) ? level_q : LEVEL_FIRST;
            discharge_en      <= (state_d == XCD_DISCHARGE);
            function_disabled <= (state_d == XCD_DISABLED);
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_disch_start;
        $rose(discharge_en);
    endsequence

    chk_discharge_latch: assert property (@(posedge ref_clk) disable iff (rst)
        discharge_en |-> line_loss_latch)
        else $error("discharge without line-loss latch");

    chk_discharge_cause: assert property (@(posedge ref_clk) disable iff (rst)
        s_disch_start |-> $past(state_q == XCD_DETECT && level_q == LEVEL_LAST))
        else $error("discharge started outside last step");

    chk_blank_quiet: assert property (@(posedge ref_clk) disable iff (rst)
        (state_q == XCD_BLANK) |-> !test_current_en && !discharge_en && !short_test_en)
        else $error("current sourced during blanking");

    chk_zc_abort: assert property (@(posedge ref_clk) disable iff (rst)
        (state_q == XCD_DETECT && zc_seen) |=> state_q == XCD_BLANK ##1 !test_current_en)
        else $error("zero-crossing did not abort test");

    chk_disch_bound: assert property (@(posedge ref_clk) disable iff (rst)
        (state_q == XCD_DISCHARGE && ms_count >= MS_W'(DISCHARGE_MS)) |=> ##1 !discharge_en)
        else $error("discharge outlasted its period");

    chk_level_step: assert property (@(posedge ref_clk) disable iff (rst)
        (state_q == XCD_DETECT && !zc_seen && step_done && level_q != LEVEL_LAST)
            |=> level_q == $past(level_q) + 2'h1)
        else $error("test level did not advance");

    chk_level_hold: assert property (@(posedge ref_clk) disable iff (rst)
        (state_q == XCD_DETECT && !step_done) |=> level_q == $past(level_q) || state_q != XCD_DETECT)
        else $error("test level moved early");

    chk_disabled_off: assert property (@(posedge ref_clk) disable iff (rst)
        (state_q == XCD_DISABLED) |=> !test_current_en && !discharge_en && !short_test_en)
        else $error("disabled function still sources current");

    chk_short_first: assert property (@(posedge ref_clk) disable iff (rst)
        (state_q == XCD_SHORT_TEST && sense_short) |=> state_q == XCD_DISABLED)
        else $error("short not detected");

endmodule

// ===== dv/xcd_line_model.sv
// Model of the AC-line sensing network that sits on the sense pins.
// Assumes the bench sets line presence and the pin short; the sequencer drives the test current.
`timescale 1ns/100ps
module xcd_line_model #(
    parameter int unsigned HALF_CYCLES = 2000
) (
    input  wire logic ref_clk,
    input  wire logic line_present,
    input  wire logic pins_shorted,
    input  wire logic test_current_en,
    output logic      line_zero_cross,
    output logic      sense_low
);
    // ------------------------------------------------------------
    // Line phase
    // ------------------------------------------------------------
    logic [15:0] phase_q = 16'h0;

    // Mains runs free whatever the controller does
    always @(posedge ref_clk) begin
        if (phase_q >= 16'(2 * HALF_CYCLES - 1)) begin
            phase_q <= 16'h0;
        end else begin
            phase_q <= phase_q + 16'h1;
        end
    end

    // ------------------------------------------------------------
    // Comparator and short level
    // ------------------------------------------------------------
    // Without test current the diode leakage keeps the pin under the threshold
    assign line_zero_cross = line_present & test_current_en & ~pins_shorted & (phase_q < 16'(HALF_CYCLES));
    assign sense_low       = pins_shorted;
endmodule

// ===== dv/xcap_discharge_sequencer_test.sv
// Self-checking bench for the discharge sequencer with the line model on its sense side.
// Assumes a shortened tick of TL cycles, so every interval runs to its end within the run.
`timescale 1ns/100ps
module xcap_discharge_sequencer_test;
    import xcd_pkg::*;

    // Cycles per millisecond tick in this bench; must stay above the tick spacing check
    localparam int unsigned TL = 20;

    logic       ref_clk = 1'b0;
    logic       rst     = 1'b1;
    logic       supply_on = 1'b0;
    logic       wake_out  = 1'b0;
    logic       line_present = 1'b0;
    logic       pins_shorted = 1'b0;
    logic       line_zero_cross;
    logic       sense_low;
    logic       short_test_en;
    logic       test_current_en;
    logic [1:0] test_level;
    logic       discharge_en;
    logic       line_loss_latch;
    logic       function_disabled;
    int         n_errors   = 0;
    int         n_compared = 0;
    int         cycles     = 0;

    initial begin
        forever #5 ref_clk = ~ref_clk;
    end

    xcd_sequencer #(.TICK_LEN(TL)) DUT (
        .ref_clk(ref_clk), .rst(rst), .supply_on(supply_on), .wake_out(wake_out),
        .line_zero_cross(line_zero_cross), .sense_low(sense_low), .short_test_en(short_test_en),
        .test_current_en(test_current_en), .test_level(test_level), .discharge_en(discharge_en),
        .line_loss_latch(line_loss_latch), .function_disabled(function_disabled)
    );

    // Half a mains period of 10 ms at the bench tick, so a crossing comes well inside the window
    xcd_line_model #(.HALF_CYCLES(200)) line_net (
        .ref_clk(ref_clk), .line_present(line_present), .pins_shorted(pins_shorted),
        .test_current_en(test_current_en), .line_zero_cross(line_zero_cross), .sense_low(sense_low)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic end_sim();
        if (n_errors == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Hang guard: the longest scenario needs well under this
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            n_errors++;
            end_sim();
        end
    end

    task automatic check(input string what, input logic [3:0] seen, input logic [3:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tick();
        @(posedge ref_clk);
        #1;
    endtask

    // Counts the cycles for which the current outputs keep their present values
    task automatic hold_len(output int n);
        logic [3:0] now_v;
        now_v = {test_current_en, discharge_en, test_level};
        n = 0;
        while ({test_current_en, discharge_en, test_level} === now_v && n < 20000) begin
            tick();
            n++;
        end
    endtask

    // One cycle of decision latency is allowed on top of the whole ticks
    task automatic check_len(input string what, input int n, input int unsigned ms);
        check(what, {3'h0, (n >= int'(ms * TL) && n <= int'(ms * TL) + 1)}, 4'h1);
    endtask

    task automatic do_reset();
        @(posedge ref_clk);
        rst <= 1'b1;
        supply_on <= 1'b0;
        wake_out <= 1'b0;
        line_present <= 1'b0;
        pins_shorted <= 1'b0;
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        tick();
        check("outputs after reset", {short_test_en, test_current_en, discharge_en, line_loss_latch}, 4'h0);
    endtask

    // Brings the sequencer into detection with level 0 on the pins
    task automatic enter_detect();
        @(posedge ref_clk);
        supply_on <= 1'b1;
        for (int i = 0; i < 20 && short_test_en !== 1'b1; i++) tick();
        check("short_test_en", {3'h0, short_test_en}, 4'h1);
        @(posedge ref_clk);
        wake_out <= 1'b1;
        for (int i = 0; i < 20 && test_current_en !== 1'b1; i++) tick();
        check("test_current_en", {3'h0, test_current_en}, 4'h1);
        check("first level", {2'h0, test_level}, {2'h0, LEVEL_FIRST});
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic sc_shorted_pins();
        do_reset();
        @(posedge ref_clk);
        pins_shorted <= 1'b1;
        supply_on <= 1'b1;
        for (int i = 0; i < 20 && function_disabled !== 1'b1; i++) tick();
        check("function_disabled", {3'h0, function_disabled}, 4'h1);
        @(posedge ref_clk);
        wake_out <= 1'b1;
        line_present <= 1'b1;
        repeat (100) tick();
        check("currents when disabled", {short_test_en, test_current_en, discharge_en, line_loss_latch}, 4'h0);
    endtask

    task automatic sc_crossing_abort();
        int n;
        do_reset();
        enter_detect();
        check("not disabled", {3'h0, function_disabled}, 4'h0);
        @(posedge ref_clk);
        line_present <= 1'b1;
        for (int i = 0; i < 4100 && test_current_en !== 1'b0; i++) tick();
        check("abort on crossing", {3'h0, test_current_en}, 4'h0);
        check("level after abort", {2'h0, test_level}, 4'h0);
        check("no discharge", {2'h0, discharge_en, line_loss_latch}, 4'h0);
        repeat (3000) tick();
        check("wait without current", {2'h0, test_current_en, discharge_en}, 4'h0);
        hold_len(n);
        check_len("wait length", n + 3000, BLANK_MS);
        check("test restarts", {1'h0, test_current_en, test_level}, {2'h1, LEVEL_FIRST});
    endtask

    // Supply and wake drop as the window opens; detection must carry on through every step
    task automatic sc_no_line();
        int n;
        do_reset();
        enter_detect();
        @(posedge ref_clk);
        supply_on <= 1'b0;
        wake_out <= 1'b0;
        #1;
        for (int lv = 0; lv < 3; lv++) begin
            hold_len(n);
            check_len("step length", n, STEP_MS);
            check("next level", {2'h0, test_level}, 4'(lv + 1));
            check("no early discharge", {2'h0, discharge_en, line_loss_latch}, 4'h0);
        end
        hold_len(n);
        check_len("last step length", n, LAST_STEP_MS);
        check("discharge on", {1'h0, discharge_en, line_loss_latch, test_current_en}, 4'h6);
        hold_len(n);
        check_len("discharge length", n, DISCHARGE_MS);
        check("blank quiet", {1'h0, discharge_en, test_current_en, line_loss_latch}, 4'h1);
        hold_len(n);
        check_len("blank length", n, BLANK_MS);
        check("retest", {line_loss_latch, test_current_en, test_level}, {2'h1, LEVEL_FIRST});
    endtask

    initial begin
        sc_shorted_pins();
        sc_crossing_abort();
        sc_no_line();
        end_sim();
    end
endmodule
